// ### shared/fac_pkg.sv
package fac_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GAIN = 8'h04;
  localparam logic [7:0] ADDR_THRESH = 8'h08;
  localparam logic [7:0] ADDR_RECLEN = 8'h0c;
  localparam logic [7:0] ADDR_GROW = 8'h10;
  localparam logic [7:0] ADDR_HOLDOFF = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_SATCNT = 8'h20;
  localparam logic [7:0] ADDR_INTERVAL = 8'h24;
  localparam logic [7:0] ADDR_ERRCNT = 8'h28;
  localparam logic [7:0] ADDR_COEF0 = 8'h40;
  localparam logic [7:0] ADDR_COEF1 = 8'h80;
  localparam int COEF_TAPS = 16;
  localparam int CTRL_FB_ON = 0;
  localparam int CTRL_SET_SEL = 1;
  localparam int CTRL_SWITCH_EN = 2;
  localparam int CTRL_EXT_TRIG = 3;
  localparam int CTRL_REARM = 4;
  localparam int CTRL_MEM_SRAM = 5;
  localparam int CMD_TRIGGER = 0;
  localparam int CMD_ARM = 1;
  localparam int CMD_POLL = 2;
  localparam int CMD_RESET_CNT = 3;
  localparam int CMD_READOUT_DONE = 4;
  localparam int HOLDOFF_GROUP = 4;
  localparam logic [23:0] MAX_LEN_BRAM = 24'h020000;
  localparam logic [23:0] MAX_LEN_SRAM = 24'h800000;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [4:0] GAIN_RESET = 5'h00;
  localparam logic [7:0] DECIM_RESET = 8'h01;
  typedef enum logic [1:0] {
    FAC_IDLE = 2'b00,
    FAC_ARMED = 2'b01,
    FAC_HOLD = 2'b10,
    FAC_REC = 2'b11
  } fac_state_t;
endpackage : fac_pkg

// ### hw/fac_top.sv
// Function
// RULE_01: Filter output reaches DAC only while feedback is on.
// RULE_02: Selected coefficient set drives the filter.
// RULE_03: Each gain step doubles output via one arithmetic shift.
// RULE_04: Record decimation is independent of processing decimation.
// RULE_05: Saturation cycles accumulate in an integrating counter.
// RULE_06: Flag set when saturated fraction exceeds threshold percent.
// RULE_07: Poll latches comparison result then clears saturation counter.
// RULE_08: Zero threshold flags any single saturation event.
// RULE_09: Record length capped at 131072 block RAM, 8388608 SRAM.
// RULE_10: Coefficient set switching only when switch enable set.
// RULE_11: Selection inverted for grow length samples during capture.
// RULE_12: Selection inverted for hold-off groups of 4 before recording.
// RULE_13: Trigger source selectable internal or external input.
// RULE_14: Software command issues internal trigger.
// RULE_15: External trigger accepted only while armed, once per arm.
// RULE_16: Rearm_a re-arms after each completed readout.
// RULE_17: Memory select routes samples to block RAM or SRAM.
// RULE_18: Clock missing status flag.
// RULE_19: Separate unlocked flags for both clock managers.
// RULE_20: Fiducial error flag on missing or jittering fiducial.
// RULE_21: Reset command clears error and interval counters.
// RULE_22: Two coefficient sets, loadable and readable back.
// RULE_23: Samples written sequentially to record length, then done.
module fac_top
  import fac_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic [7:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic HSEL_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HWDATA_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic [15:0] FILTER_DATA_I,
  input wire logic FILTER_VALID_I,
  input wire logic FILTER_SAT_I,
  input wire logic EXTERNAL_TRIGGER_INPUT_I,
  input wire logic RF_CLK_MISSING_I,
  input wire logic PROCESSING_CLOCK_MANAGER_UNLOCKED_I,
  input wire logic ACQUISITION_CLOCK_MANAGER_UNLOCKED_I,
  input wire logic FIDUCIAL_ERROR_I,
  output logic [15:0] DAC_DATA_O,
  output logic PROC_DECIM_STROBE_O,
  output logic ACTIVE_SET_O,
  output logic [15:0] MEM_WDATA_O,
  output logic [22:0] MEM_ADDR_O,
  output logic BRAM_WE_O,
  output logic SRAM_WE_O,
  output logic CAPTURE_DONE_O
);
  logic [31:0] ctrl_reg;
  logic [4:0] gain_reg;
  logic [7:0] proc_decim_reg;
  logic [7:0] record_decimation_reg;
  logic [6:0] saturation_threshold_reg;
  logic [23:0] reclen_reg;
  logic [23:0] grow_reg;
  logic [23:0] holdoff_reg;
  logic [15:0] coef_mem [0:2*COEF_TAPS-1];
  logic [31:0] sat_cnt_reg;
  logic [31:0] tot_cnt_reg;
  logic sat_flag_reg;
  logic [31:0] interval_reg;
  logic [15:0] err_cnt_reg;
  logic [1:0] ext_sync_reg;
  logic ext_prev_reg;
  logic [4:0] st_sync1_reg;
  logic [4:0] st_sync2_reg;
  logic [7:0] pdec_cnt_reg;
  logic [7:0] rdec_cnt_reg;
  logic [25:0] hold_cnt_reg;
  logic [23:0] samp_cnt_reg;
  logic armed_reg;
  logic done_reg;
  fac_state_t state_reg;
  logic ap_valid_reg;
  logic ap_write_reg;
  logic [7:0] ap_addr_reg;
  logic [31:0] cmd;
  logic ext_edge;
  logic trig;
  logic rec_tick;
  logic [23:0] len_cap;
  logic [23:0] eff_len;
  logic invert;
  logic [38:0] sat_scaled;
  logic [38:0] tot_scaled;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
    end else if (HREADY_I) begin
      ap_valid_reg <= HSEL_I && HTRANS_I[1];
      ap_write_reg <= HWRITE_I;
      ap_addr_reg <= HADDR_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  assign cmd = (ap_valid_reg && ap_write_reg && ap_addr_reg == ADDR_CMD) ? HWDATA_I : 32'h00000000;

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      ctrl_reg <= CTRL_RESET;
      gain_reg <= GAIN_RESET;
      proc_decim_reg <= DECIM_RESET;
      record_decimation_reg <= DECIM_RESET;
      saturation_threshold_reg <= 7'h00;
      reclen_reg <= 24'h000400;
      grow_reg <= 24'h000000;
      holdoff_reg <= 24'h000000;
    end else if (ap_valid_reg && ap_write_reg) begin
      unique case (ap_addr_reg)
        ADDR_CTRL: ctrl_reg <= HWDATA_I;
        ADDR_GAIN: begin
          gain_reg <= HWDATA_I[4:0];
          proc_decim_reg <= HWDATA_I[15:8];
          record_decimation_reg <= HWDATA_I[23:16];
        end
        ADDR_THRESH: saturation_threshold_reg <= HWDATA_I[6:0];
        ADDR_RECLEN: reclen_reg <= HWDATA_I[23:0];
        ADDR_GROW: grow_reg <= HWDATA_I[23:0];
        ADDR_HOLDOFF: holdoff_reg <= HWDATA_I[23:0];
        default: ;
      endcase
    end
  end

  // Coefficient store, two sets side by side
  // No reset: taps are undefined until the host loads them
  always_ff @(posedge CLK_SYS_I) begin
    if (ap_valid_reg && ap_write_reg && ap_addr_reg[7:6] != 2'b00 && ap_addr_reg[7:6] != 2'b11) begin
      coef_mem[{ap_addr_reg[7], ap_addr_reg[5:2]}] <= HWDATA_I[15:0]; // RULE_22
    end
  end

  // Read data launched at the address phase, stands through the data phase
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      HRDATA_O <= 32'h00000000;
    end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
      if (HADDR_I[7:6] == 2'b01 || HADDR_I[7:6] == 2'b10) begin
        HRDATA_O <= {16'h0, coef_mem[{HADDR_I[7], HADDR_I[5:2]}]}; // RULE_22
      end else begin
        unique case (HADDR_I)
          ADDR_CTRL: HRDATA_O <= ctrl_reg;
          ADDR_GAIN: HRDATA_O <= {8'h0, record_decimation_reg, proc_decim_reg, 3'h0, gain_reg};
          ADDR_THRESH: HRDATA_O <= {25'h0, saturation_threshold_reg};
          ADDR_RECLEN: HRDATA_O <= {8'h0, reclen_reg};
          ADDR_GROW: HRDATA_O <= {8'h0, grow_reg};
          ADDR_HOLDOFF: HRDATA_O <= {8'h0, holdoff_reg};
          ADDR_STATUS: HRDATA_O <= {24'h0, done_reg, armed_reg, sat_flag_reg, st_sync2_reg};
          ADDR_SATCNT: HRDATA_O <= sat_cnt_reg;
          ADDR_INTERVAL: HRDATA_O <= interval_reg;
          ADDR_ERRCNT: HRDATA_O <= {16'h0, err_cnt_reg};
          default: HRDATA_O <= 32'h00000000;
        endcase
      end
    end
  end

  // Status pins come from other clock domains
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      st_sync1_reg <= 5'h00;
      st_sync2_reg <= 5'h00;
      ext_sync_reg <= 2'b00;
      ext_prev_reg <= 1'b0;
    end else begin
      st_sync1_reg <= {FIDUCIAL_ERROR_I, ACQUISITION_CLOCK_MANAGER_UNLOCKED_I,
                       PROCESSING_CLOCK_MANAGER_UNLOCKED_I, RF_CLK_MISSING_I, 1'b0}; // RULE_18 RULE_19 RULE_20
      st_sync2_reg <= st_sync1_reg;
      ext_sync_reg <= {ext_sync_reg[0], EXTERNAL_TRIGGER_INPUT_I};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  // Integrating saturation counter vs threshold percent
  assign sat_scaled = {7'h0, sat_cnt_reg} * 39'd100;
  assign tot_scaled = {7'h0, tot_cnt_reg} * {32'h0, saturation_threshold_reg};
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      sat_cnt_reg <= 32'h00000000;
      tot_cnt_reg <= 32'h00000000;
      sat_flag_reg <= 1'b0;
    end else if (cmd[CMD_POLL]) begin
      sat_flag_reg <= (sat_cnt_reg != 32'h0) && (sat_scaled > tot_scaled); // RULE_06 RULE_08
      sat_cnt_reg <= {31'h0, FILTER_VALID_I && FILTER_SAT_I}; // RULE_07
      tot_cnt_reg <= {31'h0, FILTER_VALID_I};
    end else if (FILTER_VALID_I) begin
      tot_cnt_reg <= tot_cnt_reg + 32'h1;
      if (FILTER_SAT_I) begin
        sat_cnt_reg <= sat_cnt_reg + 32'h1; // RULE_05
      end
    end
  end

  // Interval and error counters
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      interval_reg <= 32'h00000000;
      err_cnt_reg <= 16'h0000;
    end else if (cmd[CMD_RESET_CNT]) begin
      interval_reg <= 32'h00000000; // RULE_21
      err_cnt_reg <= 16'h0000;
    end else if (cmd[CMD_POLL]) begin
      interval_reg <= interval_reg + 32'h1;
      if (sat_flag_reg || st_sync2_reg[4:1] != 4'h0) begin
        err_cnt_reg <= err_cnt_reg + 16'h1;
      end
    end
  end

  // Processing path: gate, shift, decimate
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      DAC_DATA_O <= 16'h0000;
      pdec_cnt_reg <= 8'h00;
      PROC_DECIM_STROBE_O <= 1'b0;
    end else begin
      PROC_DECIM_STROBE_O <= 1'b0;
      if (FILTER_VALID_I) begin
        DAC_DATA_O <= ctrl_reg[CTRL_FB_ON] ? (FILTER_DATA_I <<< gain_reg) : 16'h0000; // RULE_01 RULE_03
        if (pdec_cnt_reg + 8'h1 >= proc_decim_reg) begin
          pdec_cnt_reg <= 8'h00;
          PROC_DECIM_STROBE_O <= 1'b1;
        end else begin
          pdec_cnt_reg <= pdec_cnt_reg + 8'h1;
        end
      end
    end
  end

  // Separate record decimator
  assign rec_tick = FILTER_VALID_I && (rdec_cnt_reg + 8'h1 >= record_decimation_reg); // RULE_04
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I || state_reg != FAC_REC) begin
      rdec_cnt_reg <= 8'h00;
    end else if (FILTER_VALID_I) begin
      rdec_cnt_reg <= rec_tick ? 8'h00 : rdec_cnt_reg + 8'h1;
    end
  end

  assign len_cap = ctrl_reg[CTRL_MEM_SRAM] ? MAX_LEN_SRAM : MAX_LEN_BRAM;
  assign eff_len = (reclen_reg > len_cap || reclen_reg == 24'h0) ? len_cap : reclen_reg; // RULE_09
  assign ext_edge = ext_sync_reg[1] && !ext_prev_reg;
  assign trig = ctrl_reg[CTRL_EXT_TRIG] ? (ext_edge && armed_reg) : cmd[CMD_TRIGGER]; // RULE_13 RULE_14 RULE_15

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      armed_reg <= 1'b0;
    end else if (cmd[CMD_ARM] || (cmd[CMD_READOUT_DONE] && ctrl_reg[CTRL_REARM])) begin
      armed_reg <= 1'b1; // RULE_16
    end else if (trig) begin
      armed_reg <= 1'b0; // RULE_15
    end
  end

  // Acquisition sequencer
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      state_reg <= FAC_IDLE;
      hold_cnt_reg <= 26'h0;
      samp_cnt_reg <= 24'h0;
      done_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        FAC_IDLE, FAC_ARMED: begin
          state_reg <= armed_reg ? FAC_ARMED : FAC_IDLE;
          if (trig) begin
            done_reg <= 1'b0;
            hold_cnt_reg <= {holdoff_reg, 2'b00}; // RULE_12
            samp_cnt_reg <= 24'h0;
            state_reg <= (holdoff_reg == 24'h0) ? FAC_REC : FAC_HOLD;
          end
        end
        FAC_HOLD: begin
          if (FILTER_VALID_I) begin
            hold_cnt_reg <= hold_cnt_reg - 26'h1;
            if (hold_cnt_reg == 26'h1) begin
              state_reg <= FAC_REC;
            end
          end
        end
        FAC_REC: begin
          if (rec_tick) begin
            samp_cnt_reg <= samp_cnt_reg + 24'h1; // RULE_23
            if (samp_cnt_reg + 24'h1 >= eff_len) begin
              state_reg <= FAC_IDLE;
              done_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Inversion during hold-off and the first grow-length samples
  assign invert = ctrl_reg[CTRL_SWITCH_EN] &&
                  (state_reg == FAC_HOLD || (state_reg == FAC_REC && samp_cnt_reg < grow_reg)); // RULE_10 RULE_11 RULE_12

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      ACTIVE_SET_O <= 1'b0;
      MEM_WDATA_O <= 16'h0000;
      MEM_ADDR_O <= 23'h0;
      BRAM_WE_O <= 1'b0;
      SRAM_WE_O <= 1'b0;
      CAPTURE_DONE_O <= 1'b0;
    end else begin
      ACTIVE_SET_O <= ctrl_reg[CTRL_SET_SEL] ^ invert; // RULE_02
      BRAM_WE_O <= (state_reg == FAC_REC) && rec_tick && !ctrl_reg[CTRL_MEM_SRAM]; // RULE_17
      SRAM_WE_O <= (state_reg == FAC_REC) && rec_tick && ctrl_reg[CTRL_MEM_SRAM]; // RULE_17
      MEM_WDATA_O <= FILTER_DATA_I;
      MEM_ADDR_O <= samp_cnt_reg[22:0]; // RULE_23
      CAPTURE_DONE_O <= done_reg;
    end
  end

  a_ext_needs_arm: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_15
    (state_reg == FAC_IDLE && ctrl_reg[CTRL_EXT_TRIG] && !armed_reg) |=> state_reg inside {FAC_IDLE, FAC_ARMED})
    else $error("capture started while disarmed");
  a_gate_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_01
    !ctrl_reg[CTRL_FB_ON] && FILTER_VALID_I |=> DAC_DATA_O == 16'h0000)
    else $error("dac not blocked");
  a_gain_shift: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_03
    ctrl_reg[CTRL_FB_ON] && FILTER_VALID_I |=> DAC_DATA_O == ($past(FILTER_DATA_I) <<< $past(gain_reg)))
    else $error("gain shift wrong");
  a_no_switch: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_10
    !ctrl_reg[CTRL_SWITCH_EN] |=> ACTIVE_SET_O == $past(ctrl_reg[CTRL_SET_SEL]))
    else $error("set switched while disabled");
  a_len_cap: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_09
    state_reg == FAC_REC |-> samp_cnt_reg < eff_len)
    else $error("record too long");
  a_poll_clear: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_07
    cmd[CMD_POLL] |=> sat_cnt_reg <= 32'h1)
    else $error("sat counter not cleared");
  a_zero_thresh: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_08
    cmd[CMD_POLL] && saturation_threshold_reg == 7'h0 && sat_cnt_reg != 32'h0 |=> sat_flag_reg)
    else $error("single event missed");
  a_cnt_reset: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_21
    cmd[CMD_RESET_CNT] |=> interval_reg == 32'h0 && err_cnt_reg == 16'h0)
    else $error("counters not reset");
  a_rec_mem: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_17
    !(BRAM_WE_O && SRAM_WE_O))
    else $error("both memories written");
  a_hold_invert: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_12
    ctrl_reg[CTRL_SWITCH_EN] && state_reg == FAC_HOLD |=> ACTIVE_SET_O != $past(ctrl_reg[CTRL_SET_SEL]))
    else $error("set not inverted in hold-off");
  a_trig_disarm: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_15
    trig && !cmd[CMD_ARM] && !cmd[CMD_READOUT_DONE] |=> !armed_reg)
    else $error("still armed after trigger");
  a_addr_range: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I) // RULE_23
    BRAM_WE_O || SRAM_WE_O |-> {1'b0, MEM_ADDR_O} < eff_len)
    else $error("write beyond record length");
endmodule : fac_top

// ### test/fac_host_model.sv
module fac_host_model
  import fac_pkg::*;
(
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic [7:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [31:0] hwdata_o,
  output logic hung_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    haddr_o = 8'h00;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
    hung_o = 1'b0;
  end
  // Bounded wait, a stalled slave marks the run hung
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk_i);
    while (hready_i !== 1'b1 && n < 64) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 64) hung_o = 1'b1;
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    haddr_o <= a;
    htrans_o <= 2'b10;
    hwrite_o <= w;
    wait_rdy();
    htrans_o <= 2'b00;
    hwdata_o <= d;
    wait_rdy();
    r = hrdata_i;
  endtask : xfer
  // Command word is a one-shot, one bit per request
  task automatic cmd(input int b);
    logic [31:0] r;
    xfer(1'b1, ADDR_CMD, 32'h1 << b, r);
  endtask : cmd
endmodule : fac_host_model

// ### test/tb_top.sv
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, fval = 1'b0, fsat = 1'b0, ext = 1'b0;
  logic [15:0] fdata = 16'h0;
  logic [3:0] flt = 4'h0;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite, hrdy, hresp, hung, aset, done, bwe, swe, strb;
  logic [31:0] hwdata, hrdata, r;
  logic [15:0] dac, mwd, last_data;
  logic [22:0] maddr, last_addr;
  int miscompares = 0, samples_checked = 0, nb = 0, ns = 0, nstr = 0, ninv = 0;
  always #10 clk = ~clk;
  fac_host_model host_u (.clk_i(clk), .hready_i(hrdy), .hrdata_i(hrdata), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata), .hung_o(hung));
  fac_top dut_u (.CLK_SYS_I(clk), .RESET_I(rst), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'b010), .HSEL_I(1'b1), .HREADY_I(hrdy), .HWDATA_I(hwdata), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .FILTER_DATA_I(fdata), .FILTER_VALID_I(fval),
    .FILTER_SAT_I(fsat), .EXTERNAL_TRIGGER_INPUT_I(ext), .RF_CLK_MISSING_I(flt[0]),
    .PROCESSING_CLOCK_MANAGER_UNLOCKED_I(flt[1]), .ACQUISITION_CLOCK_MANAGER_UNLOCKED_I(flt[2]),
    .FIDUCIAL_ERROR_I(flt[3]), .DAC_DATA_O(dac), .PROC_DECIM_STROBE_O(strb), .ACTIVE_SET_O(aset),
    .MEM_WDATA_O(mwd), .MEM_ADDR_O(maddr), .BRAM_WE_O(bwe), .SRAM_WE_O(swe), .CAPTURE_DONE_O(done));
  always @(posedge clk) begin
    if (bwe === 1'b1) begin
      nb++;
      last_addr = maddr;
      last_data = mwd;
    end
    if (swe === 1'b1) ns++;
    if (strb === 1'b1) nstr++;
    if (aset === 1'b1) ninv++;
    if (hung === 1'b1) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host_u.xfer(1'b0, a, 32'h0, r);
  endtask : rd
  // One valid sample, then a gap cycle so outputs settle before checks
  task automatic sample(input logic [15:0] d, input logic s);
    @(posedge clk);
    fdata <= d;
    fval <= 1'b1;
    fsat <= s;
    @(posedge clk);
    fval <= 1'b0;
    fsat <= 1'b0;
    #1;
  endtask : sample
  task automatic run(input int n);
    for (int i = 0; i < n; i++) sample(16'(i), 1'b0);
    // Registered strobes of the last sample are counted one edge later
    repeat (2) @(posedge clk);
    #1;
  endtask : run
  task automatic ext_pulse();
    @(posedge clk);
    ext <= 1'b1;
    repeat (4) @(posedge clk);
    ext <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : ext_pulse
  task automatic t_regs();
    rd(ADDR_CTRL); `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    rd(ADDR_GAIN); `CHK(r, 32'h00010100)
    rd(8'h30); `CHK(r, 32'h0)
    wr(ADDR_COEF0, 32'h00001234);
    wr(ADDR_COEF1 + 8'h3c, 32'h0000abcd);
    rd(ADDR_COEF0); `CHK(r[15:0], 16'h1234)
    rd(ADDR_COEF1 + 8'h3c); `CHK(r[15:0], 16'habcd)
  endtask : t_regs
  task automatic t_output();
    sample(16'h0123, 1'b0); `CHK(dac, 16'h0)
    wr(ADDR_CTRL, 32'h1);
    for (int g = 0; g < 4; g++) begin
      wr(ADDR_GAIN, 32'h00010100 | 32'(g));
      sample(16'h0123, 1'b0); `CHK(dac, 16'h0123 <<< g)
    end
    wr(ADDR_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    `CHK(aset, 1'b1)
    wr(ADDR_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(aset, 1'b0)
  endtask : t_output
  task automatic t_sat();
    wr(ADDR_THRESH, 32'h0);
    host_u.cmd(CMD_POLL);
    sample(16'h0, 1'b1);
    rd(ADDR_SATCNT); `CHK(r, 32'h1)
    host_u.cmd(CMD_POLL);
    rd(ADDR_STATUS); `CHK(r[5], 1'b1)
    rd(ADDR_SATCNT); `CHK(r, 32'h0)
    wr(ADDR_THRESH, 32'd50);
    host_u.cmd(CMD_POLL);
    sample(16'h0, 1'b1);
    sample(16'h0, 1'b0);
    host_u.cmd(CMD_POLL);
    rd(ADDR_STATUS); `CHK(r[5], 1'b0)
    sample(16'h0, 1'b1);
    sample(16'h0, 1'b1);
    sample(16'h0, 1'b0);
    host_u.cmd(CMD_POLL);
    rd(ADDR_STATUS); `CHK(r[5], 1'b1)
  endtask : t_sat
  task automatic t_status();
    host_u.cmd(CMD_RESET_CNT);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      flt <= 4'h1 << i;
      repeat (4) @(posedge clk);
      rd(ADDR_STATUS); `CHK(r[4:1], 4'h1 << i)
    end
    host_u.cmd(CMD_POLL);
    rd(ADDR_ERRCNT); `CHK(r, 32'h1)
    rd(ADDR_INTERVAL); `CHK(r, 32'h1)
    host_u.cmd(CMD_RESET_CNT);
    rd(ADDR_ERRCNT); `CHK(r, 32'h0)
    rd(ADDR_INTERVAL); `CHK(r, 32'h0)
    @(posedge clk);
    flt <= 4'h0;
  endtask : t_status
  task automatic t_capture();
    wr(ADDR_CTRL, 32'h5);
    wr(ADDR_GAIN, 32'h00020300);
    wr(ADDR_RECLEN, 32'd4);
    wr(ADDR_HOLDOFF, 32'd1);
    wr(ADDR_GROW, 32'd2);
    nb = 0;
    ninv = 0;
    nstr = 0;
    host_u.cmd(CMD_TRIGGER);
    run(4);
    `CHK(nb, 0)
    `CHK(ninv != 0, 1'b1)
    `CHK(aset, 1'b1)
    run(8);
    `CHK(nb, 4)
    `CHK(last_addr, 23'd3)
    `CHK(last_data, 16'h0007)
    `CHK(aset, 1'b0)
    `CHK(done, 1'b1)
    `CHK(nstr, 4)
    wr(ADDR_CTRL, 32'h1);
    ninv = 0;
    host_u.cmd(CMD_TRIGGER);
    run(12);
    `CHK(ninv, 0)
  endtask : t_capture
  task automatic t_ext();
    wr(ADDR_CTRL, 32'h18);
    wr(ADDR_GAIN, 32'h00010100);
    wr(ADDR_HOLDOFF, 32'd0);
    wr(ADDR_GROW, 32'd0);
    nb = 0;
    ext_pulse();
    run(6);
    `CHK(nb, 0)
    host_u.cmd(CMD_ARM);
    ext_pulse();
    run(6);
    `CHK(nb, 4)
    rd(ADDR_STATUS); `CHK(r[7:6], 2'b10)
    host_u.cmd(CMD_READOUT_DONE);
    rd(ADDR_STATUS); `CHK(r[6], 1'b1)
    wr(ADDR_CTRL, 32'h38);
    ext_pulse();
    run(6);
    `CHK(ns, 4)
    `CHK(nb, 4)
  endtask : t_ext
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_output();
    t_sat();
    t_status();
    t_capture();
    t_ext();
    give_verdict();
  end
endmodule : tb_top
